//--- hw/bjc_defines.svh
// Encodings and field positions for branch_jump_control
`ifndef BJC_DEFINES_SVH
`define BJC_DEFINES_SVH
// Primary opcodes
`define OP_SPECIAL 6'h00
`define OP_REGIMM  6'h01
`define OP_J       6'h02
`define OP_JAL     6'h03
`define OP_BEQ     6'h04
`define OP_BNE     6'h05
`define OP_BLEZ    6'h06
`define OP_BGTZ    6'h07
`define OP_ADDI    6'h08
`define OP_ADDIU   6'h09
`define OP_SLTI    6'h0A
`define OP_SLTIU   6'h0B
`define OP_COP     4'h4
`define OP_LDFP    6'h31
`define OP_STFP    6'h39
// Function codes
`define FN_GOTO    6'h08
`define FN_CALLR   6'h09
`define FN_ADD     6'h20
`define FN_ADDU    6'h21
`define FN_SUB     6'h22
`define FN_SUBU    6'h23
`define FN_SLT     6'h2A
`define FN_SLTU    6'h2B
// Register-immediate selectors
`define RI_LT      5'h00
`define RI_GE      5'h01
`define RI_LTL     5'h10
`define RI_GEL     5'h11
// Coprocessor sub-operations
`define CO_MF      5'h00
`define CO_CF      5'h02
`define CO_MT      5'h04
`define CO_CT      5'h06
`define CO_BC      5'h08
// Indices and field positions
`define RA_IDX     5'h1F
`define SC_STATUS  4'hC
`define FPC_ID     5'h00
`define FPC_CSR    5'h1F
`define ST_MASK_LO 8
`define ST_MASK_HI 15
`define ST_FPU     29
`define PC_STEP    32'h0000_0004
`define LINK_STEP  32'h0000_0008
// Register bus map
`define A_CTRL     8'h00
`define A_STATE    8'h04
`define A_TRAPS    8'h08
`define CTRL_RST   4'hD
`define STATUS_RST 32'h0000_0000
`endif

//--- hw/bjc_pkg.sv
// Shared types for branch_jump_control
package bjc_pkg;
    // One general-register write-back
    typedef struct packed {
        logic        en;
        logic [4:0]  idx;
        logic [31:0] data;
    } wb_t;
    // Fetch steering after each instruction
    typedef struct packed {
        logic        slot;
        logic [31:0] pc;
    } fetch_t;
    // Exception report
    typedef struct packed {
        logic overflow;
        logic unusable;
        logic hazard;
    } exc_t;
endpackage : bjc_pkg

//--- hw/branch_jump_control.sv
// Branch, jump and coprocessor-transfer control
// Notes on behaviour
// - Absolute jump keeps upper four PC bits
// - Register jump goes to full register address
// - Calls write call address plus eight
// - Instruction after branch always executes
// - Branches PC-relative, signed 16-bit offset
// - No flags; branches test general registers
// - Trapping add/sub trap on signed overflow
// - Four true/false condition branch pairs
// - Condition one is floating compare flag
// - Condition branch needs its coprocessor enabled
// - Compare-and-set writes one or zero
// - Moves to control, fp control, fp data
// - Move result unusable by next instruction
// - Status mask change lands two instructions later
// - Fp usable bit has same delay
// - At least twelve system-control registers
// - Sixteen 64-bit fp registers as 32 words
// - Two fp control registers via control moves
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "bjc_defines.svh"

module branch_jump_control
    import bjc_pkg::*;
#(
    parameter int          SC_REGS   = 16,
    parameter int          ST_DELAY  = 2,
    // Arbitrary identity value for the fp id register
    parameter logic [31:0] FP_ID_VAL = 32'h0000_0A5A
)(
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_issue,
    input  wire logic [31:0] i_instr,
    input  wire logic [31:0] i_pc,
    input  wire logic [31:0] i_rs_val,
    input  wire logic [31:0] i_rt_val,
    input  wire logic [31:0] i_mem_rdata,
    input  wire logic [3:0]  i_cop_cond,
    input  wire logic        i_fp_cmp_valid,
    input  wire logic        i_fp_cmp_true,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [31:0]      o_rdata,
    output fetch_t           o_fetch,
    output wb_t              o_wb,
    output exc_t             o_exc,
    output logic [31:0]      o_store_data,
    output logic [7:0]       o_int_mask,
    output logic             o_fp_usable
);

    // Parameter check
    if (SC_REGS < 12 || SC_REGS > 32 || ST_DELAY < 1)
    begin : g_bad
        $error("bad parameters");
    end

    ////////////////////////////////////////////////////////////////////
    // Instruction fields

    wire logic [5:0]  op    = i_instr[31:26];   // Primary opcode
    wire logic [4:0]  rs_f  = i_instr[25:21];   // Source / sub-op
    wire logic [4:0]  rt_f  = i_instr[20:16];   // Second source
    wire logic [4:0]  rd_f  = i_instr[15:11];   // Destination
    wire logic [5:0]  fn    = i_instr[5:0];     // Function code
    wire logic [1:0]  cop_n = i_instr[27:26];   // Coprocessor number
    wire logic [31:0] simm  = {{16{i_instr[15]}}, i_instr[15:0]};

    ////////////////////////////////////////////////////////////////////
    // State

    logic [3:0]  ctrl;                  // Bus-set coprocessor enables
    logic [15:0] traps;                 // Trap counter
    logic [31:0] sc_reg [SC_REGS];      // System-control registers
    logic [31:0] fp_reg [32];           // Fp data words
    logic [31:0] fpc_csr;               // Fp control/status
    logic        fp_flag;               // Latest fp compare result
    logic        pend;                  // Taken target waits for slot
    logic [31:0] pend_pc;               // That target
    logic        prev_gv;               // Previous move wrote a gpr
    logic [4:0]  prev_gi;               // Its gpr index
    logic        prev_cv;               // Previous move wrote cop reg
    logic [6:0]  prev_ci;               // {cop, index} of that write
    logic [8:0]  st_pipe [ST_DELAY];    // Delayed {fpu, mask}

    ////////////////////////////////////////////////////////////////////
    // Decode

    wire logic is_spec  = op == `OP_SPECIAL;
    wire logic is_j     = op == `OP_J;
    wire logic is_jal   = op == `OP_JAL;
    wire logic is_goto  = is_spec && fn == `FN_GOTO;
    wire logic is_callr = is_spec && fn == `FN_CALLR;
    wire logic is_ri    = op == `OP_REGIMM;
    wire logic is_cop   = op[5:2] == `OP_COP;
    wire logic is_bc    = is_cop && rs_f == `CO_BC;
    wire logic is_ldfp  = op == `OP_LDFP;
    wire logic is_stfp  = op == `OP_STFP;
    wire logic cop_mf   = is_cop && rs_f == `CO_MF;
    wire logic cop_cf   = is_cop && rs_f == `CO_CF;
    wire logic cop_mt   = is_cop && rs_f == `CO_MT;
    wire logic cop_ct   = is_cop && rs_f == `CO_CT;

    // Coprocessor enables: fp follows delayed status
    wire logic [3:0] cop_use =
        {ctrl[3], ctrl[2], o_fp_usable, ctrl[0]};
    wire logic [1:0] mem_cop = 2'h1;
    wire logic unusable =
        ((is_cop) && !cop_use[cop_n]) ||
        ((is_ldfp || is_stfp) && !cop_use[mem_cop]);

    ////////////////////////////////////////////////////////////////////
    // Targets and conditions

    wire logic [31:0] slot_pc = i_pc + `PC_STEP;
    wire logic [31:0] link_pc = i_pc + `LINK_STEP;
    // Offset in instructions from the slot
    wire logic [31:0] br_tgt =
        slot_pc + {simm[29:0], 2'b00};
    wire logic [31:0] j_tgt =
        {i_pc[31:28], i_instr[25:0], 2'b00};

    // Register tests only, no flags
    wire logic eq   = (i_rs_val == i_rt_val) ||
                      (rs_f == 5'h00 && rt_f == 5'h00);
    wire logic neg  = i_rs_val[31];
    wire logic zero = i_rs_val == 32'h0000_0000;

    // Condition one is the fp compare flag
    wire logic [3:0] cond =
        {i_cop_cond[3:2], fp_flag, i_cop_cond[0]};
    wire logic bc_hit = cond[cop_n] == rt_f[0];

    // Branch decision
    logic br_take;
    always_comb
    begin
        case (op)
            `OP_BEQ:    br_take = eq;
            `OP_BNE:    br_take = !eq;
            `OP_BLEZ:   br_take = neg || zero;
            `OP_BGTZ:   br_take = !neg && !zero;
            `OP_REGIMM: br_take = rt_f[0] ? !neg : neg;
            default:    br_take = is_bc && !unusable &&
                                  bc_hit;
        endcase
    end

    wire logic ri_link = is_ri && (rt_f == `RI_LTL || rt_f == `RI_GEL);
    wire logic ri_ok   = is_ri && (rt_f == `RI_LT || rt_f == `RI_GE ||
                                   ri_link);
    wire logic is_br   = op == `OP_BEQ || op == `OP_BNE ||
                         op == `OP_BLEZ || op == `OP_BGTZ || ri_ok;
    wire logic take    = is_j || is_jal || is_goto || is_callr ||
                         ((is_br || is_bc) && br_take);
    // Full register address for far jumps
    wire logic [31:0] take_pc =
        (is_goto || is_callr) ? i_rs_val :
        (is_j || is_jal)      ? j_tgt : br_tgt;

    ////////////////////////////////////////////////////////////////////
    // Arithmetic and compare-and-set

    wire logic use_imm = op == `OP_ADDI || op == `OP_ADDIU;
    wire logic is_sub  = is_spec &&
                         (fn == `FN_SUB || fn == `FN_SUBU);
    wire logic [31:0] b_op   = use_imm ? simm : i_rt_val;
    wire logic [31:0] b_eff  = is_sub ? ~b_op : b_op;
    wire logic [31:0] sum    = i_rs_val + b_eff +
                               {31'h0000_0000, is_sub};
    wire logic is_addsub = use_imm || (is_spec &&
        (fn == `FN_ADD || fn == `FN_ADDU || is_sub));
    wire logic trapping  = op == `OP_ADDI || (is_spec &&
        (fn == `FN_ADD || fn == `FN_SUB));
    // Carry into the sign bit differs from carry out
    wire logic ovf = trapping &&
        (i_rs_val[31] == b_eff[31]) &&
        (sum[31] != i_rs_val[31]);

    wire logic is_slt  = (is_spec && fn == `FN_SLT) ||
                         op == `OP_SLTI;
    wire logic is_sltu = (is_spec && fn == `FN_SLTU) ||
                         op == `OP_SLTIU;
    wire logic [31:0] cmp_b = (is_spec) ? i_rt_val : simm;
    wire logic lt_s = $signed(i_rs_val) < $signed(cmp_b);
    wire logic lt_u = i_rs_val < cmp_b;
    wire logic set_bit = is_slt ? lt_s : lt_u;

    ////////////////////////////////////////////////////////////////////
    // Coprocessor reads

    wire logic [4:0] sc_i = rd_f;
    wire logic [31:0] sc_rd =
        (32'(sc_i) < SC_REGS) ? sc_reg[sc_i[$clog2(SC_REGS)-1:0]]
                             : 32'h0000_0000;
    // Only id and csr exist
    wire logic [31:0] fpc_rd =
        (rd_f == `FPC_ID)  ? FP_ID_VAL :
        (rd_f == `FPC_CSR) ? fpc_csr : 32'h0000_0000;
    wire logic [31:0] cop_rd =
        (cop_n == 2'h0) ? sc_rd :
        (cop_n == mem_cop) ? (cop_cf ? fpc_rd : fp_reg[rd_f])
                           : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // Write-back selection

    wire logic gpr_mv = (cop_mf || cop_cf) && !unusable;
    wb_t next_wb;
    always_comb
    begin
        next_wb = '0;
        if (is_jal || (ri_link))
        begin
            next_wb = '{1'b1, `RA_IDX, link_pc};
        end
        else if (is_callr)
        begin
            next_wb = '{1'b1, rd_f, link_pc};
        end
        else if (is_slt || is_sltu)
        begin
            // Three operands, result to rd or rt
            next_wb = '{1'b1, is_spec ? rd_f : rt_f,
                        {31'h0000_0000, set_bit}};
        end
        else if (is_addsub && !ovf)
        begin
            next_wb = '{1'b1, is_spec ? rd_f : rt_f, sum};
        end
        else if (gpr_mv)
        begin
            next_wb = '{1'b1, rt_f, cop_rd};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Move hazard: result unusable next instruction

    wire logic rd_hit = prev_gv && prev_gi != 5'h00 &&
                        (rs_f == prev_gi || rt_f == prev_gi);
    wire logic cop_rd_now = gpr_mv || is_stfp;
    wire logic [4:0] cop_src = is_stfp ? rt_f : rd_f;
    wire logic cr_hit = prev_cv && cop_rd_now &&
        prev_ci == {cop_n, cop_src} && !is_stfp ||
        prev_cv && is_stfp && prev_ci == {mem_cop, rt_f};
    wire logic hazard = rd_hit || cr_hit;

    // Cop register written now
    wire logic cop_wr = (cop_mt || cop_ct || is_ldfp) && !unusable;
    wire logic [6:0] cop_wi =
        is_ldfp ? {mem_cop, rt_f} : {cop_n, rd_f};
    wire logic sc_wr = cop_mt && cop_n == 2'h0 && !unusable;
    wire logic st_wr = sc_wr && rd_f == {1'b0, `SC_STATUS};

    ////////////////////////////////////////////////////////////////////
    // Fetch steering: the slot runs before the target

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pend    <= 1'b0;
            pend_pc <= 32'h0000_0000;
            o_fetch <= '0;
        end
        else if (i_issue)
        begin
            // Slot consumes the waiting target
            o_fetch <= pend ? '{1'b1, pend_pc}
                            : '{1'b0, slot_pc};
            pend    <= take && !pend;
            pend_pc <= take_pc;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Results and exceptions

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_wb  <= '0;
            o_exc <= '0;
            traps <= 16'h0000;
        end
        else
        begin
            o_wb  <= i_issue ? next_wb : '0;
            o_exc <= i_issue ? '{ovf, unusable, hazard} : '0;
            if (i_issue && (ovf || unusable))
            begin
                traps <= traps + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Move tracking

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            prev_gv <= 1'b0;
            prev_gi <= 5'h00;
            prev_cv <= 1'b0;
            prev_ci <= 7'h00;
        end
        else if (i_issue)
        begin
            prev_gv <= gpr_mv;
            prev_gi <= rt_f;
            prev_cv <= cop_wr;
            prev_ci <= cop_wi;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Floating-point state

    // Even/odd word pairs form the sixteen doubles
    always_ff @(posedge i_clk)
    begin
        if (i_issue && !unusable && (cop_n == mem_cop) && cop_mt)
        begin
            fp_reg[rd_f] <= i_rt_val;
        end
        else if (i_issue && is_ldfp && !unusable)
        begin
            fp_reg[rt_f] <= i_mem_rdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            fpc_csr      <= 32'h0000_0000;
            fp_flag      <= 1'b0;
            o_store_data <= 32'h0000_0000;
        end
        else
        begin
            if (i_issue && cop_ct && cop_n == mem_cop &&
                !unusable && rd_f == `FPC_CSR)
            begin
                fpc_csr <= i_rt_val;
            end
            if (i_fp_cmp_valid)
            begin
                fp_flag <= i_fp_cmp_true;
            end
            if (i_issue && is_stfp && !unusable)
            begin
                o_store_data <= fp_reg[rt_f];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // System-control registers

    genvar g;
    generate
        for (g = 0; g < SC_REGS; g++)
        begin : g_sc
            always_ff @(posedge i_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    sc_reg[g] <= `STATUS_RST;
                end
                else if (i_issue && sc_wr && 32'(rd_f) == g)
                begin
                    sc_reg[g] <= i_rt_val;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Delayed status, one step per issue; stage zero holds the newest

    wire logic [31:0] st_new = i_rt_val;
    generate
        for (g = 0; g < ST_DELAY; g++)
        begin : g_st
            always_ff @(posedge i_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    st_pipe[g] <= 9'h000;
                end
                else if (i_issue)
                begin
                    if (g == 0)
                    begin
                        st_pipe[g] <= st_wr
                            ? {st_new[`ST_FPU],
                               st_new[`ST_MASK_HI:`ST_MASK_LO]}
                            : st_pipe[0];
                    end
                    else
                    begin
                        st_pipe[g] <= st_pipe[g-1];
                    end
                end
            end
        end
    endgenerate

    // Effect lands ST_DELAY issues after the write
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_int_mask  <= 8'h00;
            o_fp_usable <= 1'b0;
        end
        else if (i_issue)
        begin
            o_int_mask  <= st_pipe[ST_DELAY-1][7:0];
            o_fp_usable <= st_pipe[ST_DELAY-1][8];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register port

    wire logic [31:0] state_word =
        {21'h000000, pend, fp_flag, o_fp_usable, o_int_mask};
    wire logic [31:0] bus_rd =
        (i_addr == `A_CTRL)  ? {28'h0000000, ctrl} :
        (i_addr == `A_STATE) ? state_word :
        (i_addr == `A_TRAPS) ? {16'h0000, traps} : 32'h0000_0000;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ctrl    <= `CTRL_RST;
            o_rdata <= 32'h0000_0000;
        end
        else
        begin
            if (i_wr && i_addr == `A_CTRL)
            begin
                ctrl <= i_wdata[3:0];
            end
            // Data only the cycle after
            o_rdata <= i_rd ? bus_rd : 32'h0000_0000;
        end
    end

endmodule : branch_jump_control

//--- tb/bjc_monitor.sv
// Port assertions for branch_jump_control
`timescale 1ns/1ps
`include "bjc_defines.svh"
module bjc_monitor
    import bjc_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_issue,
    input  wire logic [31:0] i_instr,
    input  wire logic [31:0] i_pc,
    input  wire logic [31:0] i_rs_val,
    input  wire fetch_t      o_fetch,
    input  wire wb_t         o_wb,
    input  wire exc_t        o_exc,
    input  wire logic [7:0]  o_int_mask
);
    ////////////////////////////////////////////////////////////////////////
    // Fields and targets of the current instruction
    wire logic [5:0]  op      = i_instr[31:26];
    wire logic [31:0] jmp_tgt = {i_pc[31:28], i_instr[25:0], 2'b00};
    wire logic [31:0] br_tgt  = i_pc + `PC_STEP +
                                {{14{i_instr[15]}}, i_instr[15:0], 2'b00};
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////////////////////////////////////
    a_link_value: assert property (
        i_issue && op == `OP_JAL |=> o_wb.en && o_wb.idx == `RA_IDX &&
        o_wb.data == $past(i_pc) + `LINK_STEP)
        else $error("bad return address");
    a_jump_target: assert property (
        i_issue && op == `OP_J ##1 i_issue |=>
        o_fetch.slot && o_fetch.pc == $past(jmp_tgt, 2))
        else $error("jump target wrong");
    a_goto_target: assert property (
        i_issue && op == 6'h00 && i_instr[5:0] == `FN_GOTO ##1 i_issue |=>
        o_fetch.slot && o_fetch.pc == $past(i_rs_val, 2))
        else $error("goto target wrong");
    a_always_branch: assert property (
        i_issue && i_instr[31:16] == 16'h1000 ##1 i_issue |=>
        o_fetch.slot && o_fetch.pc == $past(br_tgt, 2))
        else $error("zero branch target wrong");
    a_slot_order: assert property (
        i_issue |=> o_fetch.slot || o_fetch.pc == $past(i_pc) + `PC_STEP)
        else $error("delay slot skipped");
    a_trap_no_wb: assert property (
        o_exc.overflow |-> !o_wb.en && $past(i_issue))
        else $error("overflow with write-back");
    a_set_is_bit: assert property (
        i_issue && op == 6'h00 && i_instr[5:1] == 5'h15 &&
        i_instr[15:11] != 5'h00 |=> o_wb.en && o_wb.data[31:1] == 31'h0)
        else $error("set result not one bit");
    a_mask_change: assert property (
        !$stable(o_int_mask) |-> $past(i_issue))
        else $error("mask moved without issue");
endmodule : bjc_monitor

//--- tb/branch_jump_control_test.sv
// Bench for branch_jump_control
`timescale 1ns/1ps
`include "bjc_defines.svh"
module branch_jump_control_test;
    import bjc_pkg::*;
    logic        i_clk, i_arst_n, i_issue, i_wr, i_rd, cmp_req, cmp_res;
    logic [31:0] i_instr, i_pc, i_rs_val, i_rt_val, i_wdata, o_rdata;
    logic [31:0] mem_rdata, o_store_data;
    logic [7:0]  i_addr, o_int_mask;
    logic [3:0]  cop_cond;
    logic        cmp_valid, cmp_true, o_fp_usable;
    fetch_t      o_fetch;
    wb_t         o_wb;
    exc_t        o_exc;
    int          bad_count, checks;
    localparam logic [31:0] NOP = 32'h0000_0000;
    localparam logic [31:0] BCT = 32'h4501_0004;
    branch_jump_control u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_issue(i_issue), .i_instr(i_instr), .i_pc(i_pc),
        .i_rs_val(i_rs_val), .i_rt_val(i_rt_val), .i_mem_rdata(mem_rdata),
        .i_cop_cond(cop_cond), .i_fp_cmp_valid(cmp_valid),
        .i_fp_cmp_true(cmp_true), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_fetch(o_fetch),
        .o_wb(o_wb), .o_exc(o_exc), .o_store_data(o_store_data),
        .o_int_mask(o_int_mask), .o_fp_usable(o_fp_usable));
    fp_side_model u_far (.i_clk(i_clk), .i_cmp_req(cmp_req),
        .i_cmp_res(cmp_res), .o_cop_cond(cop_cond), .o_cmp_valid(cmp_valid),
        .o_cmp_true(cmp_true), .o_mem_rdata(mem_rdata));
    initial i_clk = 1'b0;
    always #25 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [39:0] got, exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Verdict, also used by the watchdog
    task automatic report_and_stop;
        $display("checks %0d bad %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // One instruction, taken at the next edge
    task automatic iss(input logic [31:0] ins, pc, rs, rt);
        @(posedge i_clk);
        i_issue  <= 1'b1;
        i_instr  <= ins;
        i_pc     <= pc;
        i_rs_val <= rs;
        i_rt_val <= rt;
    endtask : iss
    // Drop strobes, wait for settled outputs
    task automatic step;
        @(posedge i_clk);
        i_issue <= 1'b0;
        i_wr    <= 1'b0;
        i_rd    <= 1'b0;
        @(negedge i_clk);
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        step;
    endtask : wr
    // Data stand one cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        step;
        chk("rdata", 40'(o_rdata), 40'(exp));
    endtask : rd
    // Branch, its slot, then the fetch
    task automatic redir(input logic [31:0] ins, pc, rs, rt,
                         input logic [32:0] exp);
        iss(ins, pc, rs, rt);
        iss(NOP, pc + 32'h4, 32'h0, 32'h0);
        @(negedge i_clk);
        chk("slot", 40'(o_fetch), 40'({1'b0, pc + 32'h4}));
        step;
        chk("target", 40'(o_fetch), 40'(exp));
    endtask : redir
    // Arithmetic into rd 3; overflow blocks it
    task automatic alu(input logic [5:0] fn, input logic [31:0] a, b, res,
                       input logic ov);
        iss(32'h0022_1800 | {26'h0, fn}, 32'h3000, a, b);
        step;
        chk("ovf", 40'(o_exc.overflow), 40'(ov));
        chk("wb_en", 40'(o_wb.en), 40'(!ov));
        if (!ov)
            chk("wb", 40'(o_wb), 40'({1'b1, 5'h03, res}));
    endtask : alu
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {i_issue, i_wr, i_rd, cmp_req, cmp_res} = 5'h00;
        {i_instr, i_pc, i_rs_val, i_rt_val, i_wdata} = 160'h0;
        i_addr   = 8'h00;
        i_arst_n = 1'b0;
        repeat (3) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rd(`A_CTRL, 32'h0000_000D);
        rd(8'h0C, 32'h0);
        wr(`A_STATE, 32'h0000_FFFF);
        rd(`A_STATE, 32'h0);
        wr(`A_CTRL, 32'h0000_0006);
        rd(`A_CTRL, 32'h0000_0006);
        wr(`A_CTRL, 32'h0000_000D);
        iss(BCT, 32'h100, 32'h0, 32'h0);
        step;
        chk("unusable", 40'(o_exc), 40'h2);
        alu(`FN_ADD, 32'h7FFF_FFFF, 32'h1, 32'h0, 1'b1);
        alu(`FN_ADDU, 32'h7FFF_FFFF, 32'h1, 32'h8000_0000, 1'b0);
        alu(`FN_SUB, 32'h8000_0000, 32'h1, 32'h0, 1'b1);
        alu(`FN_SUBU, 32'h8000_0000, 32'h1, 32'h7FFF_FFFF, 1'b0);
        alu(`FN_SLT, 32'hFFFF_FFFF, 32'h1, 32'h1, 1'b0);
        alu(`FN_SLTU, 32'hFFFF_FFFF, 32'h1, 32'h0, 1'b0);
        rd(`A_TRAPS, 32'h3);
        redir(32'h0B00_0040, 32'hA000_0100, 0, 0, {1'b1, 32'hAC00_0100});
        redir(32'h00A0_0008, 32'h200, 32'h1234_5670, 0, {1'b1, 32'h1234_5670});
        redir(32'h1000_FFFE, 32'h2000, 0, 0, {1'b1, 32'h1FFC});
        redir(32'h1000_7FFF, 32'h2000, 0, 0, {1'b1, 32'h2_2000});
        redir(32'h1022_0004, 32'h3000, 5, 5, {1'b1, 32'h3014});
        redir(32'h1022_0004, 32'h3000, 5, 6, {1'b0, 32'h3008});
        redir(32'h0460_0010, 32'h3000, 32'h8000_0000, 0, {1'b1, 32'h3044});
        iss(32'h0C00_0010, 32'h0040_0000, 32'h0, 32'h0);
        step;
        chk("link", 40'(o_wb), 40'({1'b1, `RA_IDX, 32'h0040_0008}));
        iss(NOP, 32'h0040_0004, 32'h0, 32'h0);
        step;
        chk("call", 40'(o_fetch), 40'({1'b1, 32'h40}));
        iss(32'h4081_6000, 32'h500, 32'h0, 32'h2000_5A00);
        iss(NOP, 32'h504, 32'h0, 32'h0);
        @(negedge i_clk);
        chk("mask_a", 40'(o_int_mask), 40'h0);
        iss(NOP, 32'h508, 32'h0, 32'h0);
        @(negedge i_clk);
        chk("mask_b", 40'(o_int_mask), 40'h0);
        step;
        chk("mask_c", 40'(o_int_mask), 40'h5A);
        chk("fp_use", 40'(o_fp_usable), 40'h1);
        // Far side: a true compare
        @(posedge i_clk);
        cmp_req <= 1'b1;
        cmp_res <= 1'b1;
        @(posedge i_clk);
        cmp_req <= 1'b0;
        redir(BCT, 32'h4000, 0, 0, {1'b1, 32'h4014});
        redir(32'h4500_0004, 32'h4000, 0, 0, {1'b0, 32'h4008});
        rd(`A_STATE, 32'h0000_035A);
        iss(32'h4004_6000, 32'h600, 32'h0, 32'h0);
        iss(32'h0080_1821, 32'h604, 32'h0, 32'h0);
        @(negedge i_clk);
        chk("mv_idx", 40'(o_wb.idx), 40'h4);
        step;
        chk("hazard", 40'(o_exc), 40'h1);
        iss(32'h4481_1000, 32'h700, 32'h0, 32'hDEAD_BEEF);
        step;
        iss(32'h4406_1000, 32'h708, 32'h0, 32'h0);
        step;
        chk("fp_rd", 40'(o_wb), 40'({1'b1, 5'h06, 32'hDEAD_BEEF}));
        iss(32'hE402_0000, 32'h70C, 32'h0, 32'h0);
        step;
        chk("fp_st", 40'(o_store_data), 40'hDEAD_BEEF);
        report_and_stop;
    end
    // Watchdog
    initial
    begin
        repeat (2000) @(posedge i_clk);
        bad_count++;
        report_and_stop;
    end
endmodule : branch_jump_control_test
bind branch_jump_control bjc_monitor u_mon (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .i_issue(i_issue), .i_instr(i_instr),
    .i_pc(i_pc), .i_rs_val(i_rs_val), .o_fetch(o_fetch), .o_wb(o_wb),
    .o_exc(o_exc), .o_int_mask(o_int_mask));

//--- tb/fp_side_model.sv
// Far side: compare flag and memory word
`timescale 1ns/1ps
module fp_side_model
(
    input  wire logic        i_clk,
    input  wire logic        i_cmp_req,
    input  wire logic        i_cmp_res,
    output logic [3:0]       o_cop_cond,
    output logic             o_cmp_valid,
    output logic             o_cmp_true,
    output logic [31:0]      o_mem_rdata
);
    initial
    begin
        o_cop_cond  = 4'h5;
        o_cmp_valid = 1'b0;
        o_cmp_true  = 1'b0;
    end
    // Compare result one clock late, one pulse
    always @(posedge i_clk)
    begin
        o_cmp_valid <= i_cmp_req;
        o_cmp_true  <= i_cmp_req ? i_cmp_res : ~o_cmp_true;
        // Toggling keeps a stale level from looking steady
        o_cop_cond  <= ~o_cop_cond;
    end
    assign o_mem_rdata = 32'hC3A5_0F1E;
endmodule : fp_side_model
